//--- design/ucs_regs.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "ucs_cfg.svh"
module ucs_regs (
    input wire logic clk, // Module clock, 250 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [`UCS_ADDR_W-1:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after strobe
    input wire logic tx_room, // Core: transmit buffer freed a slot
    input wire logic tx_frame_done, // Core: frame out, buffer empty
    input wire logic tx_irq_ack, // Transmit-done interrupt serviced
    input wire logic rx_push, // Core: character received
    input wire ucs_pkg::ucs_rxch_s rx_char, // Received character
    input wire logic frame_active, // Core: frame on the wire
    input wire logic stop_mode, // System in stop mode
    input wire logic rxd_pin, // Receive pin, asynchronous
    input wire logic sclk_pin, // Serial clock pin level, asynchronous
    output ucs_pkg::ucs_cfg_s cfg, // Decoded settings
    output logic irq, // Interrupt request
    output logic wake_irq, // Wake interrupt request
    output logic sclk_oe, // Serial clock pin output enable
    output logic sclk_run, // Master serial clock may toggle
    output logic ss_oe, // Slave-select pin output enable
    output logic sample_pulse, // Sample edge of serial clock
    output logic setup_pulse, // Setup edge of serial clock
    output logic soft_rst, // Soft reset pulse to core
    output logic tx_load, // Transmit byte load pulse
    output logic [7:0] tx_data // Transmit byte
);
    import ucs_pkg::*;

    ucs_state_s s; // Registered state
    ucs_state_s n; // Next state
    logic wr_c1, wr_c2, wr_c3, wr_st, wr_dt; // Write decodes
    logic rd_dt; // Data read decode
    logic pop; // Head character consumed
    logic accept; // Received character stored
    logic [1:0] cnt_mid; // Count after pop
    logic sclk_rise, sclk_fall; // Synchronised clock edges
    logic smp_rise; // Sample edge is rising

    // Settings decode; reserved codes never disturb the other fields
    function automatic ucs_cfg_s decode_cfg(input logic [7:0] c1, input logic [7:0] c2,
                                            input logic [7:0] c3);
        ucs_cfg_s d;
        logic spi;
        d = '0;
        spi = (c1[7:6] == `UCS_MODE_SPI);
        d.operating_mode_select = c1[7:6];
        d.parity_select = c1[5:4];
        d.char_length_select = spi ? 3'h3 : c1[3:1];
        d.bit_order_select = spi & c1[2];
        d.clock_phase_select = spi & c1[1];
        d.clock_polarity_select = c1[0];
        d.transmitter_enable = c2[`UCS_B_TX_EN];
        d.receiver_enable = c2[`UCS_B_RX_EN];
        d.module_enable = c2[`UCS_B_MOD_EN];
        d.double_speed_select = (c1[7:6] == `UCS_MODE_ASYNC) & c2[`UCS_B_DBL];
        d.loopback_enable = c3[`UCS_B_LOOP];
        d.stop_bit_select = ~spi & c3[`UCS_B_STOP2];
        d.transmit_ninth_bit = c3[`UCS_B_TX9];
        // Reserved mode, parity or length park the core
        d.mode_idle = (c1[7:6] == `UCS_MODE_RSVD) | (c1[5:4] == `UCS_PAR_RSVD)
                    | (~spi & c1[3:1] > `UCS_LEN_MAX8 & c1[3:1] != `UCS_LEN_NINE);
        return d;
    endfunction : decode_cfg

    // Address decode for the plain register port
    assign wr_c1 = wr & (addr == `UCS_OFS_CTRL1);
    assign wr_c2 = wr & (addr == `UCS_OFS_CTRL2);
    assign wr_c3 = wr & (addr == `UCS_OFS_CTRL3);
    assign wr_st = wr & (addr == `UCS_OFS_STAT);
    assign wr_dt = wr & (addr == `UCS_OFS_DATA);
    assign rd_dt = rd & (addr == `UCS_OFS_DATA);
    assign pop = rd_dt & (s.rx_cnt != 2'h0);
    assign cnt_mid = s.rx_cnt - {1'b0, pop};
    // Frames count only while the unit and module run and no overrun holds
    assign accept = rx_push & s.cfg.receiver_enable & s.cfg.module_enable
                  & ~s.cfg.mode_idle & ~s.overrun_flag & (cnt_mid != `UCS_RX_DEPTH);
    // Edges come only from the second and third sync stages
    assign sclk_rise = s.sclk_s2 & ~s.sclk_s3;
    assign sclk_fall = ~s.sclk_s2 & s.sclk_s3;
    // Sync mode behaves like phase 1: setup on leading edge, sample on trailing
    assign smp_rise = ~s.cfg.clock_polarity_select
                    ^ ((s.cfg.operating_mode_select == `UCS_MODE_SPI)
                       ? s.cfg.clock_phase_select : 1'b1);

    // Next-state logic for every register of the block
    always_comb begin
        n = s;
        n.rxd_s1 = rxd_pin;
        n.rxd_s2 = s.rxd_s1;
        n.sclk_s1 = sclk_pin;
        n.sclk_s2 = s.sclk_s1;
        n.sclk_s3 = s.sclk_s2;
        n.rdata = 8'h00;
        n.tx_load = 1'b0;
        n.soft_rst = 1'b0;
        // Control writes
        if (wr_c1) begin
            n.ctrl1 = wdata;
        end
        if (wr_c2) begin
            n.ctrl2 = wdata;
        end
        if (wr_c3) begin
            n.ctrl3 = {wdata[7:4], 1'b0, wdata[2:1], 1'b0};
        end
        // Data writes load the transmit buffer and take its room
        if (wr_dt) begin
            n.tx_data = wdata;
            n.tx_load = 1'b1;
            n.buffer_empty_flag = 1'b0;
        end
        // Status writes: zero clears, clears applied before sets
        if (wr_st) begin
            if (!wdata[`UCS_B_EMPTY]) begin
                n.buffer_empty_flag = 1'b0;
            end
            if (!wdata[`UCS_B_DONE]) begin
                n.transmit_done_flag = 1'b0;
            end
            if (!wdata[`UCS_B_WAKE]) begin
                n.wake_flag = 1'b0;
            end
        end
        // Servicing the interrupt clears transmit done
        if (tx_irq_ack) begin
            n.transmit_done_flag = 1'b0;
        end
        // Reading the buffer ends overrun and retires the head character
        if (pop) begin
            n.rx_ptr = ~s.rx_ptr;
            n.overrun_flag = 1'b0;
        end
        n.rx_cnt = cnt_mid;
        // Hardware sets win over same-cycle clears, except a soft reset, which wins over them
        if (tx_room) begin
            n.buffer_empty_flag = 1'b1;
        end
        if (tx_frame_done && s.cfg.transmitter_enable && s.cfg.module_enable) begin
            n.transmit_done_flag = 1'b1;
        end
        if (stop_mode && !s.rxd_s2 && s.cfg.operating_mode_select == `UCS_MODE_ASYNC) begin
            n.wake_flag = 1'b1;
        end
        // Store a new character with its error flags
        if (accept) begin
            // Tail slot counts from the old head, so a same-cycle pop is safe
            n.rx_mem[s.rx_ptr ^ s.rx_cnt[0]] = '{ninth: rx_char.ninth,
                                               ferr: rx_char.ferr,
                                               perr: rx_char.perr
                                                     & (s.cfg.parity_select != `UCS_PAR_NONE),
                                               data: rx_char.data};
            n.rx_cnt = cnt_mid + 2'h1;
        end else if (rx_push && s.cfg.receiver_enable && s.cfg.module_enable
                     && cnt_mid == `UCS_RX_DEPTH) begin
            n.overrun_flag = 1'b1;
        end
        // Soft reset restarts the module logic, settings kept
        if (wr_st && wdata[`UCS_B_SRST]) begin
            n.soft_rst = 1'b1;
            n.buffer_empty_flag = 1'b1;
            n.transmit_done_flag = 1'b0;
            n.wake_flag = 1'b0;
            n.overrun_flag = 1'b0;
            n.rx_cnt = 2'h0;
            n.rx_ptr = 1'b0;
        end
        // Read data, valid only in the cycle after the strobe
        if (rd) begin
            unique case (addr)
                `UCS_OFS_CTRL1: n.rdata = s.ctrl1;
                `UCS_OFS_CTRL2: n.rdata = s.ctrl2;
                // Ninth received bit of the head character
                `UCS_OFS_CTRL3: n.rdata = {s.ctrl3[7:1],
                                           (s.rx_cnt != 2'h0) & s.rx_mem[s.rx_ptr].ninth};
                `UCS_OFS_STAT: n.rdata = {s.buffer_empty_flag, s.transmit_done_flag,
                                          s.rx_cnt != 2'h0, s.wake_flag, 1'b0,
                                          s.overrun_flag,
                                          (s.rx_cnt != 2'h0) & s.rx_mem[s.rx_ptr].ferr,
                                          (s.rx_cnt != 2'h0) & s.rx_mem[s.rx_ptr].perr};
                `UCS_OFS_DATA: n.rdata = pop ? s.rx_mem[s.rx_ptr].data : 8'h00;
                default: n.rdata = 8'h00;
            endcase
        end
        n.cfg = decode_cfg(n.ctrl1, n.ctrl2, n.ctrl3);
        // Interrupt request from each enabled flag
        n.irq = (n.buffer_empty_flag & n.ctrl2[`UCS_B_EMPTY_IE])
              | (n.transmit_done_flag & n.ctrl2[`UCS_B_DONE_IE])
              | ((n.rx_cnt != 2'h0) & n.ctrl2[`UCS_B_RECV_IE]);
        n.wake_irq = n.wake_flag & n.ctrl2[`UCS_B_WAKE_IE];
        // Pin directions follow master and select-output bits
        n.sclk_oe = (n.ctrl1[7:6] == `UCS_MODE_SYNC || n.ctrl1[7:6] == `UCS_MODE_SPI)
                  & n.ctrl3[`UCS_B_MASTER];
        n.ss_oe = (n.ctrl1[7:6] == `UCS_MODE_SPI) & n.ctrl3[`UCS_B_MASTER]
                & n.ctrl3[`UCS_B_SS_OUT];
        // Free-running clock unless gated to frames
        n.sclk_run = n.sclk_oe & n.ctrl2[`UCS_B_MOD_EN] & ~n.cfg.mode_idle
                   & (~n.ctrl3[`UCS_B_GATE] | frame_active);
        // Edge strobes for the shifter, quiet when the module is off
        n.sample_pulse = s.cfg.module_enable & ~s.cfg.mode_idle
                       & (smp_rise ? sclk_rise : sclk_fall);
        n.setup_pulse = s.cfg.module_enable & ~s.cfg.mode_idle
                      & (smp_rise ? sclk_fall : sclk_rise);
    end

    // Single state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.buffer_empty_flag <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flops
    assign rdata = s.rdata;
    assign cfg = s.cfg;
    assign irq = s.irq;
    assign wake_irq = s.wake_irq;
    assign sclk_oe = s.sclk_oe;
    assign sclk_run = s.sclk_run;
    assign ss_oe = s.ss_oe;
    assign sample_pulse = s.sample_pulse;
    assign setup_pulse = s.setup_pulse;
    assign soft_rst = s.soft_rst;
    assign tx_load = s.tx_load;
    assign tx_data = s.tx_data;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Empty flag with its enable raises the request next cycle
    irq_empty_a: assert property (
        (s.buffer_empty_flag && s.ctrl2[`UCS_B_EMPTY_IE] && !wr && !tx_irq_ack) |=> irq)
        else $error("empty flag enabled but no interrupt");
    wake_req_a: assert property (
        (stop_mode && !s.rxd_s2 && s.cfg.operating_mode_select == `UCS_MODE_ASYNC
         && s.ctrl2[`UCS_B_WAKE_IE] && !wr && !rd) |=> wake_irq)
        else $error("wake interrupt missing");
    done_set_a: assert property (
        (tx_frame_done && s.cfg.transmitter_enable && s.cfg.module_enable
         && !(wr_st && wdata[`UCS_B_SRST])) |=> s.transmit_done_flag)
        else $error("transmit done not set");
    empty_clear_a: assert property (
        (wr_st && !wdata[`UCS_B_EMPTY] && !wdata[`UCS_B_SRST] && !tx_room)
        |=> !s.buffer_empty_flag)
        else $error("empty flag not cleared by write of zero");
    recv_count_a: assert property (
        (accept && !pop && !(wr_st && wdata[`UCS_B_SRST])) |=> s.rx_cnt == $past(s.rx_cnt) + 2'h1)
        else $error("received character not counted");
    overrun_hold_a: assert property (
        (s.overrun_flag && !pop && !wr_st) |=> s.overrun_flag && s.rx_cnt == $past(s.rx_cnt))
        else $error("overrun flag dropped or frame stored");
    soft_pulse_a: assert property (
        (wr_st && wdata[`UCS_B_SRST]) |=> soft_rst && s.rx_cnt == 2'h0
        ##1 (!soft_rst || $past(wr_st && wdata[`UCS_B_SRST])))
        else $error("soft reset not a single pulse");
    clk_dir_a: assert property (
        (wr_c3 && wdata[`UCS_B_MASTER] && s.ctrl1[7:6] == `UCS_MODE_SPI && !wr_c1) |=> sclk_oe)
        else $error("master did not drive serial clock");
    ss_dir_a: assert property (
        ss_oe |-> s.ctrl3[`UCS_B_MASTER] && s.ctrl3[`UCS_B_SS_OUT]
                  && s.ctrl1[7:6] == `UCS_MODE_SPI)
        else $error("select pin driven outside master SPI");
    idle_rsvd_a: assert property (
        (s.ctrl1[7:6] == `UCS_MODE_RSVD) |-> cfg.mode_idle ##1 !sample_pulse && !setup_pulse)
        else $error("reserved mode not held idle");
endmodule : ucs_regs

//--- pkg/ucs_cfg.svh
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH
// Register offsets on the plain register port
`define UCS_ADDR_W 8
`define UCS_OFS_CTRL1 8'he2
`define UCS_OFS_CTRL2 8'he3
`define UCS_OFS_CTRL3 8'he4
`define UCS_OFS_STAT 8'he5
`define UCS_OFS_DATA 8'he7
// Reset values
`define UCS_RST_CTRL 8'h00
`define UCS_RST_STAT 8'h80
// Mode field codes
`define UCS_MODE_ASYNC 2'h0
`define UCS_MODE_SYNC 2'h1
`define UCS_MODE_RSVD 2'h2
`define UCS_MODE_SPI 2'h3
// Parity field codes
`define UCS_PAR_NONE 2'h0
`define UCS_PAR_RSVD 2'h1
// Length codes, only 000..011 and 111 are legal
`define UCS_LEN_NINE 3'h7
`define UCS_LEN_MAX8 3'h3
// Control 2 bit positions
`define UCS_B_EMPTY_IE 7
`define UCS_B_DONE_IE 6
`define UCS_B_RECV_IE 5
`define UCS_B_WAKE_IE 4
`define UCS_B_TX_EN 3
`define UCS_B_RX_EN 2
`define UCS_B_MOD_EN 1
`define UCS_B_DBL 0
// Control 3 bit positions
`define UCS_B_MASTER 7
`define UCS_B_LOOP 6
`define UCS_B_GATE 5
`define UCS_B_SS_OUT 4
`define UCS_B_STOP2 2
`define UCS_B_TX9 1
`define UCS_B_RX9 0
// Status bit positions
`define UCS_B_EMPTY 7
`define UCS_B_DONE 6
`define UCS_B_RECV 5
`define UCS_B_WAKE 4
`define UCS_B_SRST 3
`define UCS_B_OVR 2
`define UCS_B_FERR 1
`define UCS_B_PERR 0
// Receive buffer depth in characters
`define UCS_RX_DEPTH 2'h2
`endif

//--- pkg/ucs_pkg.sv
package ucs_pkg;
    // Decoded settings handed to the serial core
    typedef struct packed {
        logic [1:0] operating_mode_select; // Mode code
        logic [1:0] parity_select; // Parity code
        logic [2:0] char_length_select; // Length code
        logic bit_order_select; // 1 = MSB first (SPI only)
        logic clock_phase_select; // SPI phase
        logic clock_polarity_select; // Serial clock polarity
        logic transmitter_enable; // Transmit unit runs
        logic receiver_enable; // Receive unit runs
        logic module_enable; // Module clock supplied
        logic double_speed_select; // Async double speed
        logic loopback_enable; // Loop-back test mode
        logic stop_bit_select; // 1 = two stop bits
        logic transmit_ninth_bit; // Ninth bit to send
        logic mode_idle; // Reserved code held idle
    } ucs_cfg_s;

    // One received character with its status
    typedef struct packed {
        logic ninth; // Ninth data bit
        logic ferr; // First stop bit was low
        logic perr; // Bad parity
        logic [7:0] data; // Data byte
    } ucs_rxch_s;

    // All state of the register block
    typedef struct packed {
        logic [7:0] ctrl1; // mode_frame_control
        logic [7:0] ctrl2; // enable_interrupt_control
        logic [7:0] ctrl3; // master_stopbit_control, written bits
        logic buffer_empty_flag; // Transmit buffer has room
        logic transmit_done_flag; // Frame fully shifted out
        logic wake_flag; // Receive line low in stop mode
        logic overrun_flag; // Character lost
        logic [1:0] rx_cnt; // Unread characters
        logic rx_ptr; // Head slot index
        ucs_rxch_s [1:0] rx_mem; // Two-deep receive buffer
        logic [7:0] rdata; // Read data, one cycle late
        logic irq; // Combined interrupt request
        logic wake_irq; // Wake interrupt request
        logic rxd_s1; // Receive pin sync stage 1
        logic rxd_s2; // Receive pin sync stage 2
        logic sclk_s1; // Serial clock sync stage 1
        logic sclk_s2; // Serial clock sync stage 2
        logic sclk_s3; // Serial clock edge history
        logic sample_pulse; // Sample edge seen
        logic setup_pulse; // Setup edge seen
        logic sclk_oe; // Drive serial clock pin
        logic sclk_run; // Master clock may toggle
        logic ss_oe; // Drive slave-select pin
        logic soft_rst; // Module soft reset pulse
        logic tx_load; // Transmit byte loaded
        logic [7:0] tx_data; // Transmit byte
        ucs_cfg_s cfg; // Decoded settings
    } ucs_state_s;
endpackage : ucs_pkg

//--- sim/ucs_link_model.sv
`timescale 1ns/100ps
// Far-side serial device: makes the link clock and drives the receive line
module ucs_link_model (
    input wire logic clk, // Bench clock, paces frame starts only
    input wire logic start, // Begin one eight-pulse frame
    input wire logic pol, // Serial clock idle level
    input wire logic hold_low, // Pull receive line low
    output logic sclk_pin, // Serial clock toward the block
    output logic rxd_pin, // Receive line, idle high
    output logic busy // Frame in progress
);
    // Line rests high between characters, as an idle async line does
    assign rxd_pin = !hold_low;
    // Clock stands at idle level outside frames, 160 ns period inside
    initial begin
        busy = 1'b0;
        sclk_pin = 1'b0;
        forever begin
            // Pin moves on falling bench edges, clear of the block's sampling edge
            @(negedge clk);
            sclk_pin = pol;
            if (start) begin
                busy = 1'b1;
                // Leading edge leaves idle level, trailing edge returns
                repeat (8) begin
                    #80 sclk_pin = !pol;
                    #80 sclk_pin = pol;
                end
                busy = 1'b0;
            end
        end
    end
endmodule : ucs_link_model

//--- sim/ucs_regs_tb.sv
`timescale 1ns/100ps
`include "ucs_cfg.svh"
module ucs_regs_tb;
    import ucs_pkg::*;
    logic clk, rst_n, wr, rd, frame_active, stop_mode, link_start, link_pol, hold_low;
    logic busy, rxd_pin, sclk_pin, irq, wake_irq, sclk_oe, sclk_run, ss_oe;
    logic sample_pulse, setup_pulse, soft_rst, tx_load, exp_lvl;
    logic [3:0] evt; // Core events: room, frame done, ack, push
    logic [7:0] addr, wdata, rdata, tx_data, rv, v;
    ucs_rxch_s rx_char; // Character offered with a push
    ucs_cfg_s cfg; // Decoded settings seen
    int err_count, samples_checked, cycles, samp_cnt, setup_cnt, bad_edge, load_cnt, srst_cnt;
    int b0, b1, b2;
    logic [7:0] t1 [11] = '{8'h06, 8'h46, 8'hc6, 8'h86, 8'h26, 8'h36, 8'h16, 8'h08, 8'h0e,
        8'hc5, 8'h00};
    logic [7:0] te [5] = '{8'hc0, 8'hc2, 8'hc1, 8'hc3, 8'h46};
    logic [7:0] m1 [5] = '{8'h46, 8'h46, 8'hc6, 8'hc6, 8'h46};
    logic [7:0] m3 [5] = '{8'h80, 8'h00, 8'h90, 8'h80, 8'h10};
    wire tx_room = evt[3];
    wire tx_frame_done = evt[2];
    wire tx_irq_ack = evt[1];
    wire rx_push = evt[0];

    ucs_regs ucs_regs_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .tx_room(tx_room), .tx_frame_done(tx_frame_done),
        .tx_irq_ack(tx_irq_ack), .rx_push(rx_push), .rx_char(rx_char),
        .frame_active(frame_active), .stop_mode(stop_mode), .rxd_pin(rxd_pin),
        .sclk_pin(sclk_pin), .cfg(cfg), .irq(irq), .wake_irq(wake_irq), .sclk_oe(sclk_oe),
        .sclk_run(sclk_run), .ss_oe(ss_oe), .sample_pulse(sample_pulse),
        .setup_pulse(setup_pulse), .soft_rst(soft_rst), .tx_load(tx_load), .tx_data(tx_data));
    ucs_link_model ucs_link_model_inst (.clk(clk), .start(link_start), .pol(link_pol),
        .hold_low(hold_low), .sclk_pin(sclk_pin), .rxd_pin(rxd_pin), .busy(busy));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pulse counters and hang guard; pin level is stable long before a pulse
    always @(posedge clk) begin
        cycles++;
        if (sample_pulse) begin
            samp_cnt++;
            if (sclk_pin !== exp_lvl) bad_edge++;
        end
        if (setup_pulse) begin
            setup_cnt++;
            if (sclk_pin !== !exp_lvl) bad_edge++;
        end
        if (tx_load === 1'b1) load_cnt++;
        if (soft_rst === 1'b1) srst_cnt++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
        end
    endtask : check
    // One-cycle write strobe
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
        check(rv, exp, msg);
    endtask : rd_chk
    // One-cycle core event
    task ev(input int k);
        @(posedge clk);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt <= 4'h0;
    endtask : ev
    // Registered outputs follow a write one cycle later
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        {rst_n, wr, rd, frame_active, stop_mode, link_start, link_pol, hold_low} = '0;
        {evt, addr, wdata, rx_char, exp_lvl} = '0;
        {err_count, samples_checked, cycles, samp_cnt, setup_cnt, bad_edge} = '0;
        {load_cnt, srst_cnt} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped hole
        rd_chk(`UCS_OFS_CTRL1, 8'h00, "ctrl1 reset");
        rd_chk(`UCS_OFS_CTRL2, 8'h00, "ctrl2 reset");
        rd_chk(`UCS_OFS_CTRL3, 8'h00, "ctrl3 reset");
        rd_chk(`UCS_OFS_STAT, 8'h80, "status reset");
        rd_chk(8'he0, 8'h00, "unmapped");
        $display("test reset finished");
        // Every mode and parity code, length codes 000, 011, 100 and 111; reserved ones idle the module
        foreach (t1[k]) begin
            v = t1[k];
            wr_reg(`UCS_OFS_CTRL1, v);
            settle();
            check(8'(cfg.mode_idle), 8'((v[7:6] == 2) || (v[5:4] == 1) ||
                ((v[7:6] != 3) && (v[3:1] inside {3'h4, 3'h5, 3'h6}))), "idle");
            check(8'(cfg.operating_mode_select), 8'(v[7:6]), "mode");
            check(8'(cfg.parity_select), 8'(v[5:4]), "parity");
            if (v[7:6] != 3) check(8'(cfg.char_length_select), 8'(v[3:1]), "length");
            else check(8'({cfg.bit_order_select, cfg.clock_phase_select,
                cfg.clock_polarity_select}), 8'(v[2:0]), "spi bits");
            rd_chk(`UCS_OFS_CTRL1, v, "ctrl1 back");
        end
        // Unit enables each way round
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h0a : 8'h05;
            wr_reg(`UCS_OFS_CTRL2, v);
            settle();
            check(8'({cfg.transmitter_enable, cfg.receiver_enable, cfg.module_enable,
                cfg.double_speed_select}), v, "enables");
        end
        // Transmit done ignored while the module clock is off
        wr_reg(`UCS_OFS_CTRL2, 8'h08);
        ev(2);
        rd_chk(`UCS_OFS_STAT, 8'h80, "done gated");
        // Pin directions by mode and master select
        foreach (m1[k]) begin
            wr_reg(`UCS_OFS_CTRL1, m1[k]);
            wr_reg(`UCS_OFS_CTRL3, m3[k]);
            settle();
            check(8'(sclk_oe), 8'(m3[k][7]), "clock pin dir");
            check(8'(ss_oe), 8'(m3[k][7] && m3[k][4] && m1[k][7:6] == 3), "select pin");
        end
        wr_reg(`UCS_OFS_CTRL1, 8'h06);
        wr_reg(`UCS_OFS_CTRL3, 8'h46);
        settle();
        check(8'({cfg.loopback_enable, cfg.stop_bit_select, cfg.transmit_ninth_bit}), 8'h07,
            "frame bits");
        rd_chk(`UCS_OFS_CTRL3, 8'h46, "ctrl3 back");
        // Gated master clock runs only with a frame on the wire
        wr_reg(`UCS_OFS_CTRL2, 8'h02);
        wr_reg(`UCS_OFS_CTRL1, 8'h46);
        wr_reg(`UCS_OFS_CTRL3, 8'ha0);
        settle();
        check(8'(sclk_run), 8'h00, "gated idle");
        @(posedge clk);
        frame_active <= 1'b1;
        settle();
        check(8'(sclk_run), 8'h01, "gated frame");
        @(posedge clk);
        frame_active <= 1'b0;
        wr_reg(`UCS_OFS_CTRL3, 8'h80);
        settle();
        check(8'(sclk_run), 8'h01, "free running");
        $display("test config finished");
        // Sample and setup edges for all SPI formats and one synchronous slave frame
        wr_reg(`UCS_OFS_CTRL3, 8'h00);
        foreach (te[k]) begin
            v = te[k];
            link_pol <= v[0];
            wr_reg(`UCS_OFS_CTRL1, v);
            exp_lvl = (v[0] == ((v[7:6] == 3) ? v[1] : 1'b1));
            repeat (20) @(posedge clk);
            {b0, b1, b2} = {samp_cnt, setup_cnt, bad_edge};
            @(posedge clk);
            link_start <= 1'b1;
            @(posedge clk);
            link_start <= 1'b0;
            @(negedge busy);
            repeat (10) @(posedge clk);
            check(8'(samp_cnt - b0), 8'h08, "sample edges");
            check(8'(setup_cnt - b1), 8'h08, "setup edges");
            check(8'(bad_edge - b2), 8'h00, "edge level");
        end
        $display("test edges finished");
        // Receive buffer: two deep, overrun, error flags of the head character
        wr_reg(`UCS_OFS_CTRL1, 8'h2e);
        wr_reg(`UCS_OFS_CTRL3, 8'h00);
        wr_reg(`UCS_OFS_CTRL2, 8'h2e);
        rx_char <= {1'b1, 1'b1, 1'b0, 8'h5a};
        ev(0);
        settle();
        check(8'(irq), 8'h01, "receive irq");
        rd_chk(`UCS_OFS_STAT, 8'ha2, "one char");
        rd_chk(`UCS_OFS_CTRL3, 8'h01, "ninth in");
        @(posedge clk);
        rx_char <= {1'b0, 1'b0, 1'b1, 8'ha5};
        ev(0);
        rx_char <= {1'b0, 1'b0, 1'b0, 8'h33};
        ev(0);
        rd_chk(`UCS_OFS_STAT, 8'ha6, "overrun");
        rd_chk(`UCS_OFS_DATA, 8'h5a, "first char");
        rd_chk(`UCS_OFS_STAT, 8'ha1, "second head");
        rd_chk(`UCS_OFS_DATA, 8'ha5, "second char");
        rd_chk(`UCS_OFS_STAT, 8'h80, "drained");
        check(8'(irq), 8'h00, "receive irq off");
        $display("test receive finished");
        // Transmit flags
        b0 = load_cnt;
        wr_reg(`UCS_OFS_DATA, 8'h3c);
        settle();
        check(tx_data, 8'h3c, "tx byte");
        check(8'(load_cnt - b0), 8'h01, "tx load");
        rd_chk(`UCS_OFS_STAT, 8'h00, "buffer full");
        ev(3);
        rd_chk(`UCS_OFS_STAT, 8'h80, "buffer room");
        wr_reg(`UCS_OFS_CTRL2, 8'h4e);
        ev(2);
        settle();
        check(8'(irq), 8'h01, "done irq");
        rd_chk(`UCS_OFS_STAT, 8'hc0, "done set");
        ev(1);
        rd_chk(`UCS_OFS_STAT, 8'h80, "done serviced");
        check(8'(irq), 8'h00, "done irq off");
        ev(2);
        wr_reg(`UCS_OFS_STAT, 8'h00);
        rd_chk(`UCS_OFS_STAT, 8'h00, "write zero");
        ev(3);
        $display("test transmit finished");
        // Wake from stop mode on a low receive line
        wr_reg(`UCS_OFS_CTRL1, 8'h06);
        wr_reg(`UCS_OFS_CTRL2, 8'h12);
        stop_mode <= 1'b1;
        hold_low <= 1'b1;
        repeat (8) @(posedge clk);
        check(8'(wake_irq), 8'h01, "wake irq");
        rd_chk(`UCS_OFS_STAT, 8'h90, "wake flag");
        @(posedge clk);
        hold_low <= 1'b0;
        stop_mode <= 1'b0;
        wr_reg(`UCS_OFS_STAT, 8'h80);
        rd_chk(`UCS_OFS_STAT, 8'h80, "wake cleared");
        check(8'(wake_irq), 8'h00, "wake irq off");
        // Soft reset pulses once and reads back zero
        b0 = srst_cnt;
        wr_reg(`UCS_OFS_STAT, 8'h08);
        settle();
        check(8'(srst_cnt - b0), 8'h01, "soft reset");
        rd_chk(`UCS_OFS_STAT, 8'h80, "soft reset bit");
        $display("test wake and soft reset finished");
        report_and_stop();
    end
endmodule : ucs_regs_tb
